// >>> hw/controller_status_flag_bank.sv
// status and control relay bank of the programmable controller
//
// Summary of operation
// - fast pulse relay, 10 ms period, even duty
// - tenth pulse relay, 100 ms period, even duty
// - second pulse relay, 1 s period, even duty
// - minute pulse relay, 1 min period, even duty
// - error summary is OR of six faults
// - zero flag set when sum/difference is zero
// - borrow flag set on subtraction underflow
// - carry flag on add carry or shift overflow
// - done flag when multi-scan operation finishes
// - control bit selects 100 ms or 10 ms base
// - either clear bit wipes images and values
// - hold bit keeps memory across run-to-stop
// - outputs-off bit forces every output contact off
// - fixed scan waits for scan time first
// - closed run monitor is inverse of open
// - clock presence relay always asserted
`timescale 1ns/10ps
`default_nettype none
`include "status_bank_cfg.svh"
module controller_status_flag_bank
  import status_bank_pkg::*;
#(
  parameter int unsigned BASE_TICK_CYC = `CFG_BASE_TICK_CYC,
  parameter int unsigned OUT_W         = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             run_switch_pin,
  input  wire logic             scan_end,
  input  wire arith_req_t       arith_req,
  input  wire logic             multi_scan_done,
  input  wire fault_vec_t       faults,
  input  wire logic             timer_base_select,
  input  wire logic             volatile_memory_clear,
  input  wire logic             retained_memory_clear,
  input  wire logic             hold_on_stop,
  input  wire logic             outputs_off_control,
  input  wire logic             fixed_scan_enable,
  input  wire logic [15:0]      fixed_scan_time,
  input  wire logic [OUT_W-1:0] output_image,
  output var  logic             run_monitor_open,
  output var  logic             run_monitor_closed,
  output var  logic             first_scan_pulse_open,
  output var  logic             first_scan_pulse_closed,
  output var  logic             scan_start,
  output var  logic             error_summary_flag,
  output var  logic [3:0]       error_summary_code,
  output var  logic             pulse_period_fast,
  output var  logic             pulse_period_tenth,
  output var  logic             pulse_period_second,
  output var  logic             pulse_period_minute,
  output var  logic             rtc_present_flag,
  output var  logic             arith_zero_flag,
  output var  logic             arith_borrow_flag,
  output var  logic             arith_carry_flag,
  output var  logic             instr_done_flag,
  output var  logic             timer_tick,
  output var  logic             memory_clear,
  output var  logic             stop_clear,
  output var  logic [OUT_W-1:0] output_contacts
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (BASE_TICK_CYC < 2) $error("BASE_TICK_CYC must be at least 2");
    if (OUT_W < 1) $error("OUT_W must be at least 1");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // lowest numbered active fault, zero when none
  function automatic logic [3:0] fault_code(input fault_vec_t f);
    logic [3:0] c;
    c = `CFG_RST_CODE;
    if (f.operation_fault_flag) c = 4'h6;
    if (f.circuit_fault_flag)   c = 4'h5;
    if (f.syntax_fault_flag)    c = 4'h4;
    if (f.param_fault_flag)     c = 4'h3;
    if (f.port_comm_fault_flag) c = 4'h2;
    if (f.hardware_fault_flag)  c = 4'h1;
    return c;
  endfunction : fault_code

  // ----------------------------------------------------------------
  // base tick, one per ms
  // ----------------------------------------------------------------
  logic ms_tick;

  tick_div #(
    .N (BASE_TICK_CYC)
  ) u_ms_tick (
    .clk    (clk),
    .resetn (resetn),
    .tick   (ms_tick)
  );

  // ----------------------------------------------------------------
  // free running pulse relays
  // ----------------------------------------------------------------
  localparam int unsigned HALF_MS [4] = '{
    `CFG_FAST_HALF_MS, `CFG_TENTH_HALF_MS,
    `CFG_SECOND_HALF_MS, `CFG_MINUTE_HALF_MS
  };

  logic [3:0]  pulse_reg;
  logic [14:0] half_cnt_reg [4];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pulse
      logic half_done;
      assign half_done = (half_cnt_reg[gi] == 15'(HALF_MS[gi] - 1));
      // counting base ticks keeps the slow relay off a huge counter
      always_ff @(posedge clk) begin
        if (!resetn) begin
          half_cnt_reg[gi] <= '0;
          pulse_reg[gi]    <= `CFG_RST_FLAG;
        end else if (ms_tick) begin
          half_cnt_reg[gi] <= half_done ? '0 : half_cnt_reg[gi] + 15'h0001;
          if (half_done) pulse_reg[gi] <= !pulse_reg[gi];
        end
      end
      a_pulse_half: assert property (
        $changed(pulse_reg[gi]) |->
          $past(ms_tick) && $past(half_cnt_reg[gi]) == 15'(HALF_MS[gi] - 1))
        else $error("pulse relay toggled off its half period");
    end
  endgenerate

  assign pulse_period_fast   = pulse_reg[0];
  assign pulse_period_tenth  = pulse_reg[1];
  assign pulse_period_second = pulse_reg[2];
  assign pulse_period_minute = pulse_reg[3];

  // ----------------------------------------------------------------
  // timer time base
  // ----------------------------------------------------------------
  logic [6:0] tbase_cnt_reg;
  logic [6:0] tbase_last;
  logic       tbase_wrap;

  assign tbase_last = timer_base_select ? 7'(`CFG_TIMER_FINE_MS - 1)
                                        : 7'(`CFG_TIMER_COARSE_MS - 1);
  assign tbase_wrap = ms_tick && tbase_cnt_reg >= tbase_last;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tbase_cnt_reg <= '0;
      timer_tick    <= `CFG_RST_FLAG;
    end else begin
      if (ms_tick) tbase_cnt_reg <= tbase_wrap ? '0 : tbase_cnt_reg + 7'h01;
      timer_tick <= tbase_wrap;
    end
  end

  a_tbase_fine: assert property (
    (timer_base_select && ms_tick && tbase_cnt_reg == 7'h09) |=> timer_tick)
    else $error("fine time base did not tick at 10 ms");

  // ----------------------------------------------------------------
  // run switch input, three stage synchroniser
  // ----------------------------------------------------------------
  logic run_s1_reg;
  logic run_s2_reg;
  logic run_s3_reg;
  logic run_lvl_reg;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_ff @(posedge clk) begin
    if (!resetn) begin
      run_s1_reg  <= 1'b0;
      run_s2_reg  <= 1'b0;
      run_s3_reg  <= 1'b0;
      run_lvl_reg <= 1'b0;
    end else begin
      run_s1_reg <= run_switch_pin;
      run_s2_reg <= run_s1_reg;
      run_s3_reg <= run_s2_reg;
      if (run_s2_reg == run_s3_reg) run_lvl_reg <= run_s3_reg;
    end
  end

  // ----------------------------------------------------------------
  // scan sequencer with fixed scan wait
  // ----------------------------------------------------------------
  scan_state_t state_reg;
  scan_state_t state_next;
  logic [15:0] elapsed_reg;
  logic        time_met;
  logic        start_now;
  logic        first_reg;

  assign time_met = !fixed_scan_enable || elapsed_reg >= fixed_scan_time;

  always_comb begin
    state_next = state_reg;
    start_now  = 1'b0;
    unique case (state_reg)
      SCAN_STOP: begin
        if (run_lvl_reg) begin
          state_next = SCAN_RUN;
          start_now  = 1'b1;
        end
      end
      SCAN_RUN: begin
        if (!run_lvl_reg) state_next = SCAN_STOP;
        else if (scan_end && time_met) start_now = 1'b1;
        else if (scan_end) state_next = SCAN_WAIT;
      end
      SCAN_WAIT: begin
        if (!run_lvl_reg) state_next = SCAN_STOP;
        else if (time_met) begin
          state_next = SCAN_RUN;
          start_now  = 1'b1;
        end
      end
      default: state_next = SCAN_STOP;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg   <= SCAN_STOP;
      elapsed_reg <= '0;
      scan_start  <= `CFG_RST_FLAG;
      first_reg   <= `CFG_RST_FLAG;
    end else begin
      state_reg  <= state_next;
      scan_start <= start_now;
      // saturate so a long scan never wraps into a short one
      if (start_now) elapsed_reg <= '0;
      else if (ms_tick && elapsed_reg != 16'hFFFF) elapsed_reg <= elapsed_reg + 16'h0001;
      if (state_reg == SCAN_STOP && start_now) first_reg <= 1'b1;
      else if (start_now || state_next == SCAN_STOP) first_reg <= 1'b0;
    end
  end

  a_fixed_wait: assert property (
    (state_reg == SCAN_WAIT && fixed_scan_enable
     && elapsed_reg < fixed_scan_time) |=> !scan_start)
    else $error("scan started before fixed scan time");

  // ----------------------------------------------------------------
  // run monitors and first scan pulse
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      run_monitor_open        <= 1'b0;
      run_monitor_closed      <= 1'b1;
      first_scan_pulse_open   <= 1'b0;
      first_scan_pulse_closed <= 1'b1;
    end else begin
      run_monitor_open        <= state_next != SCAN_STOP;
      run_monitor_closed      <= state_next == SCAN_STOP;
      first_scan_pulse_open   <= first_reg;
      first_scan_pulse_closed <= !first_reg;
    end
  end

  a_run_inverse: assert property (
    run_monitor_closed == !run_monitor_open)
    else $error("run monitors not complementary");
  a_first_inverse: assert property (
    first_scan_pulse_closed == !first_scan_pulse_open)
    else $error("first scan pulses not complementary");
  a_first_scan_once: assert property (
    (state_reg != SCAN_STOP && start_now && first_reg) |=> ##1 !first_scan_pulse_open)
    else $error("first scan pulse outlived the first scan");

  // ----------------------------------------------------------------
  // error summary
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      error_summary_flag <= `CFG_RST_FLAG;
      error_summary_code <= `CFG_RST_CODE;
    end else begin
      error_summary_flag <= |faults;
      error_summary_code <= fault_code(faults);
    end
  end

  a_error_or: assert property (
    ##1 error_summary_flag == $past(|faults))
    else $error("error summary not the OR of faults");

  // ----------------------------------------------------------------
  // arithmetic flags
  // ----------------------------------------------------------------
  arith_flag_unit u_arith (
    .clk         (clk),
    .resetn      (resetn),
    .req         (arith_req),
    .zero_flag   (arith_zero_flag),
    .borrow_flag (arith_borrow_flag),
    .carry_flag  (arith_carry_flag)
  );

  // ----------------------------------------------------------------
  // instruction complete, cleared as the next scan starts
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      instr_done_flag <= `CFG_RST_FLAG;
    end else begin
      // the set wins so a completion on the clear edge survives
      if (multi_scan_done) instr_done_flag <= 1'b1;
      else if (scan_start) instr_done_flag <= 1'b0;
    end
  end

  a_done_set: assert property (multi_scan_done |=> instr_done_flag)
    else $error("completion lost");

  // ----------------------------------------------------------------
  // memory clear, hold and output disable
  // ----------------------------------------------------------------
  logic run_stop_edge;

  assign run_stop_edge = state_reg != SCAN_STOP && state_next == SCAN_STOP;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rtc_present_flag <= `CFG_RST_RTC_PRESENT;
      memory_clear     <= `CFG_RST_FLAG;
      stop_clear       <= `CFG_RST_FLAG;
      output_contacts  <= '0;
    end else begin
      rtc_present_flag <= 1'b1;
      memory_clear     <= volatile_memory_clear || retained_memory_clear;
      stop_clear       <= run_stop_edge && !hold_on_stop;
      // clear and disable also blank the contacts on the same edge
      if (outputs_off_control || volatile_memory_clear || retained_memory_clear)
        output_contacts <= '0;
      else output_contacts <= output_image;
    end
  end

  a_rtc_on: assert property (rtc_present_flag)
    else $error("clock presence relay dropped");
  a_clear_any: assert property (
    (volatile_memory_clear || retained_memory_clear) |=> memory_clear)
    else $error("memory clear not issued");
  a_hold_stop: assert property (
    (run_stop_edge && hold_on_stop) |=> !stop_clear)
    else $error("memory cleared despite hold");
  a_outputs_off: assert property (
    outputs_off_control |=> output_contacts == '0)
    else $error("contacts driven while disabled");

endmodule : controller_status_flag_bank
`default_nettype wire

// >>> hw/status_bank_cfg.svh
// constants for the controller status flag bank
`ifndef STATUS_BANK_CFG_SVH
`define STATUS_BANK_CFG_SVH

// ----------------------------------------------------------------
// clock and base tick
// ----------------------------------------------------------------
`define CFG_CLK_PERIOD_NS   10
`define CFG_BASE_TICK_NS    1000000
`define CFG_BASE_TICK_CYC   (`CFG_BASE_TICK_NS / `CFG_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// pulse relay half periods, in base ticks (ms)
// ----------------------------------------------------------------
`define CFG_FAST_PERIOD_MS    10
`define CFG_TENTH_PERIOD_MS   100
`define CFG_SECOND_PERIOD_S   1
`define CFG_MINUTE_PERIOD_S   60
`define CFG_MS_PER_S          1000
`define CFG_FAST_HALF_MS      (`CFG_FAST_PERIOD_MS / 2)
`define CFG_TENTH_HALF_MS     (`CFG_TENTH_PERIOD_MS / 2)
`define CFG_SECOND_HALF_MS    (`CFG_SECOND_PERIOD_S * `CFG_MS_PER_S / 2)
`define CFG_MINUTE_HALF_MS    (`CFG_MINUTE_PERIOD_S * `CFG_MS_PER_S / 2)

// ----------------------------------------------------------------
// timer time base, in base ticks (ms)
// ----------------------------------------------------------------
`define CFG_TIMER_FINE_MS     10
`define CFG_TIMER_COARSE_MS   100

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CFG_RST_FLAG          1'b0
`define CFG_RST_RTC_PRESENT   1'b1
`define CFG_RST_CODE          4'h0

`endif

// >>> hw/status_bank_pkg.sv
// types shared by the controller status flag bank
package status_bank_pkg;

  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_ADD   = 2'b01,
    OP_SUB   = 2'b10,
    OP_SHIFT = 2'b11
  } arith_op_t;

  typedef struct packed {
    logic        valid;
    arith_op_t   op;
    logic [15:0] a;
    logic [15:0] b;
  } arith_req_t;

  typedef struct packed {
    logic hardware_fault_flag;
    logic port_comm_fault_flag;
    logic param_fault_flag;
    logic syntax_fault_flag;
    logic circuit_fault_flag;
    logic operation_fault_flag;
  } fault_vec_t;

  typedef enum logic [1:0] {
    SCAN_STOP = 2'b00,
    SCAN_RUN  = 2'b01,
    SCAN_WAIT = 2'b10
  } scan_state_t;

endpackage : status_bank_pkg

// >>> hw/tick_div.sv
// divider giving a one-cycle tick every n clocks
`timescale 1ns/10ps
`default_nettype none
module tick_div #(
  parameter int unsigned N = 100000
) (
  input  wire logic clk,
  input  wire logic resetn,
  output var  logic tick
);
  localparam int unsigned CW = $clog2(N + 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          wrap;

  initial begin
    if (N < 2) $error("tick_div needs N of at least 2");
  end

  assign wrap     = (cnt_reg == CW'(N - 1));
  assign cnt_next = wrap ? '0 : cnt_reg + CW'(1);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= wrap;
    end
  end

  a_tick_spacing: assert property (@(posedge clk) disable iff (!resetn)
    tick |-> cnt_reg == '0)
    else $error("tick out of step with counter");
endmodule : tick_div
`default_nettype wire

// >>> hw/arith_flag_unit.sv
// zero, borrow and carry flags from add, subtract and shift
`timescale 1ns/10ps
`default_nettype none
`include "status_bank_cfg.svh"
module arith_flag_unit
  import status_bank_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire arith_req_t req,
  output var  logic       zero_flag,
  output var  logic       borrow_flag,
  output var  logic       carry_flag
);
  logic [16:0] sum_ext;
  logic [16:0] diff_ext;
  logic        add_op;
  logic        sub_op;
  logic        shf_op;
  logic        res_zero;
  logic        add_carry;
  logic        sub_borrow;

  assign add_op   = req.valid && req.op == OP_ADD;
  assign sub_op   = req.valid && req.op == OP_SUB;
  assign shf_op   = req.valid && req.op == OP_SHIFT;
  assign sum_ext  = {req.a[15], req.a} + {req.b[15], req.b};
  assign diff_ext = {req.a[15], req.a} - {req.b[15], req.b};
  assign res_zero = add_op ? (sum_ext[15:0] == 16'h0000)
                           : (diff_ext[15:0] == 16'h0000);
  // carry means the signed sum passed the top of the range
  assign add_carry  = !sum_ext[16] && sum_ext[15];
  // borrow means the signed difference fell under the bottom
  assign sub_borrow = diff_ext[16] && !diff_ext[15];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      zero_flag   <= `CFG_RST_FLAG;
      borrow_flag <= `CFG_RST_FLAG;
      carry_flag  <= `CFG_RST_FLAG;
    end else begin
      if (add_op || sub_op) zero_flag <= res_zero;
      if (sub_op) borrow_flag <= sub_borrow;
      if (add_op) carry_flag <= add_carry;
      else if (shf_op) carry_flag <= req.a[15];
    end
  end

  a_zero_result: assert property (@(posedge clk) disable iff (!resetn)
    (add_op || sub_op) |=> zero_flag == $past(res_zero))
    else $error("zero flag does not follow result");
  a_borrow_below: assert property (@(posedge clk) disable iff (!resetn)
    (sub_op && diff_ext[16] && !diff_ext[15]) |=> borrow_flag)
    else $error("borrow missed on underflow");
  a_carry_shift: assert property (@(posedge clk) disable iff (!resetn)
    (shf_op && req.a[15]) |=> carry_flag)
    else $error("carry missed on shift overflow");
endmodule : arith_flag_unit
`default_nettype wire

// >>> test/test_controller_status_flag_bank.sv
// self-checking bench for the controller status flag bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAITFOR(c) begin #1; k = 0; while (!(c) && k < 5000) begin \
  @(posedge clk); #1; k++; end `CHK((c), 1'b1) end
module test_controller_status_flag_bank
  import status_bank_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  localparam int B = 4;  // short base tick keeps the second relay affordable
  logic        clk, resetn, run_switch_pin, scan_end, multi_scan_done, timer_base_select;
  logic        volatile_memory_clear, retained_memory_clear, hold_on_stop;
  logic        outputs_off_control, fixed_scan_enable;
  logic [15:0] fixed_scan_time, output_image, output_contacts;
  arith_req_t  arith_req;
  fault_vec_t  faults;
  logic        run_monitor_open, run_monitor_closed, first_scan_pulse_open;
  logic        first_scan_pulse_closed, scan_start, error_summary_flag;
  logic [3:0]  error_summary_code, pulses;
  logic        pulse_period_fast, pulse_period_tenth, pulse_period_second;
  logic        pulse_period_minute, rtc_present_flag, arith_zero_flag;
  logic        arith_borrow_flag, arith_carry_flag, instr_done_flag;
  logic        timer_tick, memory_clear, stop_clear, p;
  int          k, n, n_fail = 0, compares = 0, sc_cnt = 0, cyc_n = 0;
  int          halves [3] = '{5, 50, 500};

  assign pulses = {pulse_period_minute, pulse_period_second, pulse_period_tenth,
                   pulse_period_fast};

  controller_status_flag_bank #(.BASE_TICK_CYC(B), .OUT_W(16)) i_dut (
    .clk(clk), .resetn(resetn), .run_switch_pin(run_switch_pin), .scan_end(scan_end),
    .arith_req(arith_req), .multi_scan_done(multi_scan_done), .faults(faults),
    .timer_base_select(timer_base_select), .volatile_memory_clear(volatile_memory_clear),
    .retained_memory_clear(retained_memory_clear), .hold_on_stop(hold_on_stop),
    .outputs_off_control(outputs_off_control), .fixed_scan_enable(fixed_scan_enable),
    .fixed_scan_time(fixed_scan_time), .output_image(output_image),
    .run_monitor_open(run_monitor_open), .run_monitor_closed(run_monitor_closed),
    .first_scan_pulse_open(first_scan_pulse_open),
    .first_scan_pulse_closed(first_scan_pulse_closed), .scan_start(scan_start),
    .error_summary_flag(error_summary_flag), .error_summary_code(error_summary_code),
    .pulse_period_fast(pulse_period_fast), .pulse_period_tenth(pulse_period_tenth),
    .pulse_period_second(pulse_period_second), .pulse_period_minute(pulse_period_minute),
    .rtc_present_flag(rtc_present_flag), .arith_zero_flag(arith_zero_flag),
    .arith_borrow_flag(arith_borrow_flag), .arith_carry_flag(arith_carry_flag),
    .instr_done_flag(instr_done_flag), .timer_tick(timer_tick),
    .memory_clear(memory_clear), .stop_clear(stop_clear), .output_contacts(output_contacts)
  );

  // ----------------------------------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (stop_clear === 1'b1) sc_cnt++;
    cyc_n++;
    if (cyc_n == 30000) begin  // generous: the planned run is near 4k cycles
      n_fail++;
      end_sim();
    end
  end

  task end_sim();
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : step

  task arith(input arith_op_t op, input logic [15:0] a, b, input logic z, bo, c);
    @(posedge clk) arith_req <= '{1'b1, op, a, b};
    @(posedge clk) arith_req.valid <= 1'b0;
    step(1);
    `CHK(arith_zero_flag, z)
    `CHK(arith_borrow_flag, bo)
    `CHK(arith_carry_flag, c)
  endtask : arith

  task end_scan();
    @(posedge clk) scan_end <= 1'b1;
    @(posedge clk) scan_end <= 1'b0;
  endtask : end_scan

  // cycles in one level of a pulse relay, after its next edge
  task half(input int i, output int m);
    step(1);
    p = pulses[i];
    k = 0;
    while (pulses[i] === p && k < 9000) begin step(1); k++; end
    p = pulses[i];
    m = 0;
    while (pulses[i] === p && m < 9000) begin step(1); m++; end
  endtask : half

  task tgap(output int m);
    k = 0;
    while (timer_tick !== 1'b1 && k < 2000) begin step(1); k++; end
    m = 0;
    do begin step(1); m++; end while (timer_tick !== 1'b1 && m < 2000);
  endtask : tgap

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {resetn, run_switch_pin, scan_end, multi_scan_done, timer_base_select} = '0;
    {volatile_memory_clear, retained_memory_clear, hold_on_stop} = '0;
    {outputs_off_control, fixed_scan_enable} = '0;
    arith_req = '0; // only inputs driven, never a device relay
    faults = '0;
    fixed_scan_time = 16'h0000;
    output_image = 16'hA5C3;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    step(1);
    `CHK(rtc_present_flag, 1'b1)
    `CHK(run_monitor_closed, 1'b1)
    `CHK(first_scan_pulse_closed, 1'b1)
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) faults <= fault_vec_t'(6'h20 >> i);
      step(2);
      `CHK(error_summary_flag, 1'b1)
      `CHK(error_summary_code, 4'(i + 1))
    end
    @(posedge clk) faults <= '0;
    step(2);
    `CHK(error_summary_flag, 1'b0)
    arith(OP_ADD, 16'h7FFF, 16'h0001, 1'b0, 1'b0, 1'b1);
    arith(OP_ADD, 16'h0001, 16'hFFFF, 1'b1, 1'b0, 1'b0);
    arith(OP_SUB, 16'h8000, 16'h0001, 1'b0, 1'b1, 1'b0);
    arith(OP_SUB, 16'h0005, 16'h0005, 1'b1, 1'b0, 1'b0);
    arith(OP_SHIFT, 16'h8000, 16'h0000, 1'b1, 1'b0, 1'b1);
    arith(OP_SHIFT, 16'h4000, 16'h0000, 1'b1, 1'b0, 1'b0);
    arith(OP_NONE, 16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0);
    `CHK(output_contacts, 16'hA5C3)
    @(posedge clk) outputs_off_control <= 1'b1;
    step(2);
    `CHK(output_contacts, 16'h0000)
    @(posedge clk) {outputs_off_control, volatile_memory_clear} <= 2'b01;
    step(2);
    `CHK(memory_clear, 1'b1)
    `CHK(output_contacts, 16'h0000)
    @(posedge clk) {volatile_memory_clear, retained_memory_clear} <= 2'b01;
    step(2);
    `CHK(memory_clear, 1'b1)
    @(posedge clk) retained_memory_clear <= 1'b0;
    step(2);
    `CHK(memory_clear, 1'b0)
    `CHK(output_contacts, 16'hA5C3)
    tgap(n);
    tgap(n);
    `CHK(n, 100 * B)
    @(posedge clk) timer_base_select <= 1'b1;
    tgap(n);
    tgap(n);
    `CHK(n, 10 * B)
    for (int i = 0; i < 3; i++) begin
      half(i, n);
      `CHK(n, halves[i] * B)
    end
    `CHK(pulse_period_minute, 1'b0)
    @(posedge clk) run_switch_pin <= 1'b1;
    `WAITFOR(run_monitor_open)
    `CHK(run_monitor_closed, 1'b0)
    `WAITFOR(first_scan_pulse_open)
    `CHK(first_scan_pulse_closed, 1'b0)
    @(posedge clk) multi_scan_done <= 1'b1;
    @(posedge clk) multi_scan_done <= 1'b0;
    step(1);
    `CHK(instr_done_flag, 1'b1)
    end_scan();
    step(3);
    `CHK(first_scan_pulse_open, 1'b0)
    `CHK(first_scan_pulse_closed, 1'b1)
    `CHK(instr_done_flag, 1'b0)
    @(posedge clk) {fixed_scan_enable, fixed_scan_time} <= {1'b1, 16'h0003};
    end_scan();
    `WAITFOR(scan_start)
    end_scan();
    // sample off the edge; the wait is quantised to whole base ticks
    #1 n = 2;
    while (scan_start !== 1'b1 && n < 1000) begin step(1); n++; end
    `CHK(n > 2 * B && n <= 3 * B + 1, 1'b1)
    @(posedge clk) {hold_on_stop, run_switch_pin} <= 2'b10;
    `WAITFOR(!run_monitor_open)
    step(2);
    `CHK(sc_cnt, 0)
    @(posedge clk) run_switch_pin <= 1'b1;
    `WAITFOR(run_monitor_open)
    @(posedge clk) {hold_on_stop, run_switch_pin} <= 2'b00;
    `WAITFOR(!run_monitor_open)
    step(2);
    `CHK(sc_cnt, 1)
    end_sim();
  end
endmodule : test_controller_status_flag_bank
`default_nettype wire
